// >>> rsm_deglitch.sv
`timescale 1ns/1ps
module rsm_deglitch
    import rsm_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic bypass,
    input  wire logic sel_req,
    output logic      sel_applied
);

    // ****************************************************************
    // Switch only after the request has stood still long enough
    // ****************************************************************
    logic [3:0] cnt_r;
    logic       sel_r;
    wire        differs  = sel_req != sel_r;
    wire        settled  = cnt_r >= RSM_DEGLITCH_CYCLES - 4'h1;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sel_r <= 1'b0;
            cnt_r <= 4'h0;
        end else if (!differs) begin
            cnt_r <= 4'h0;
        end else if (bypass || settled) begin
            sel_r <= sel_req;
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    assign sel_applied = sel_r;

endmodule

// >>> rsm_pkg.sv
package rsm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [9:0] RSM_REF_CTRL_ADDR = 10'h01C;
    localparam logic [7:0] RSM_REF_CTRL_RST  = 8'h00;

    // Field positions of reference_select_control
    localparam int RSM_BIT_DEGLITCH_OFF = 7;
    localparam int RSM_BIT_MANUAL_SEL   = 6;
    localparam int RSM_BIT_USE_PIN      = 5;
    localparam int RSM_BIT_AUTO_SWITCH  = 4;
    localparam int RSM_BIT_KEEP_SECOND  = 3;
    localparam int RSM_BIT_REF_TWO_PWR  = 2;
    localparam int RSM_BIT_REF_ONE_PWR  = 1;
    localparam int RSM_BIT_DIFF_MODE    = 0;

    // ****************************************************************
    // Monitor select codes (low four bits; bit 4 picks polarity except for codes 1-4, 9, A and F)
    // ****************************************************************
    localparam logic [3:0] RSM_MON_RAIL       = 4'h0;
    localparam logic [3:0] RSM_MON_REF_ONE    = 4'h1;
    localparam logic [3:0] RSM_MON_REF_TWO    = 4'h2;
    localparam logic [3:0] RSM_MON_SEL_CLK    = 4'h3;
    localparam logic [3:0] RSM_MON_UNSEL_CLK  = 4'h4;
    localparam logic [3:0] RSM_MON_SEL_GOOD   = 4'h5;
    localparam logic [3:0] RSM_MON_UNSEL_GOOD = 4'h6;
    localparam logic [3:0] RSM_MON_ONE_FREQ   = 4'h7;
    localparam logic [3:0] RSM_MON_TWO_FREQ   = 4'h8;
    localparam logic [3:0] RSM_MON_BOTH_FREQ  = 4'h9;
    localparam logic [3:0] RSM_MON_LOCK_ALL   = 4'hA;
    localparam logic [3:0] RSM_MON_OSC_FREQ   = 4'hB;
    localparam logic [3:0] RSM_MON_WHICH_REF  = 4'hC;
    localparam logic [3:0] RSM_MON_LOCK       = 4'hD;
    localparam logic [3:0] RSM_MON_HOLDOVER   = 4'hE;
    localparam logic [3:0] RSM_MON_RESERVED   = 4'hF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int         RSM_CLK_PERIOD_NS    = 8;
    localparam int         RSM_DEGLITCH_TIME_NS = 32;
    localparam logic [3:0] RSM_DEGLITCH_CYCLES  =
        4'((RSM_DEGLITCH_TIME_NS + RSM_CLK_PERIOD_NS - 1) / RSM_CLK_PERIOD_NS);

    // Automatic switchover states
    typedef enum logic [0:0] {
        RSM_ON_FIRST  = 1'b0,
        RSM_ON_SECOND = 1'b1
    } rsm_auto_t;

endpackage

// >>> rsm_props.sv
`timescale 1ns/1ps
module rsm_props
    import rsm_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [9:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] monitor_sel,
    input wire logic       ref_one_freq_good,
    input wire logic       ref_two_freq_good,
    input wire logic       osc_freq_good,
    input wire logic       digital_lock_flag,
    input wire logic       monitor_pin,
    input wire logic       selected_ref,
    input wire logic       ref_one_power_on,
    input wire logic       ref_two_power_on,
    input wire logic       diff_mode
);
    // ********************************
    // Register and monitor checks
    // ********************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire hit = reg_wr && reg_addr == RSM_REF_CTRL_ADDR;
    sequence wr_once;
        hit ##1 !hit;
    endsequence
    read_back_a: assert property (hit ##1 reg_addr == RSM_REF_CTRL_ADDR |-> reg_rdata == $past(reg_wdata))
        else $error("readback differs from write");
    one_power_a: assert property (wr_once |=> ref_one_power_on == ($past(reg_wdata[1], 2) | $past(reg_wdata[4], 2)))
        else $error("first input power wrong");
    two_power_a: assert property (wr_once |=> ref_two_power_on == ($past(reg_wdata[2], 2) | $past(reg_wdata[4], 2)))
        else $error("second input power wrong");
    diff_mode_a: assert property (wr_once |=> diff_mode == $past(reg_wdata[0], 2))
        else $error("differential mode wrong");
    osc_low_a: assert property (monitor_sel == 5'h1B |=> monitor_pin == !$past(osc_freq_good))
        else $error("oscillator status wrong");
    lock_low_a: assert property (monitor_sel == 5'h1D |=> monitor_pin == !$past(digital_lock_flag))
        else $error("lock status wrong");
    freq_and_a: assert property (monitor_sel == 5'h19 |=> monitor_pin == $past(ref_one_freq_good & ref_two_freq_good))
        else $error("frequency and wrong");
    which_ref_a: assert property (monitor_sel == 5'h1C |=> monitor_pin == !selected_ref)
        else $error("selected input level wrong");
    freq_high_a: assert property (monitor_sel == 5'h07 |=> monitor_pin == $past(ref_one_freq_good))
        else $error("active high status wrong");
    cover property (wr_once);
    cover property ($rose(selected_ref));
    cover property (monitor_sel == 5'h1C ##1 !monitor_pin);
endmodule

bind rsm_top rsm_props u_props (.core_clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .monitor_sel,
    .ref_one_freq_good, .ref_two_freq_good, .osc_freq_good, .digital_lock_flag, .monitor_pin, .selected_ref,
    .ref_one_power_on, .ref_two_power_on, .diff_mode);

// >>> rsm_ref_src.sv
`timescale 1ns/1ps
module rsm_ref_src (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic power_one,
    input  wire logic power_two,
    output logic      ref_one,
    output logic      ref_two
);
    // ********************************
    // Sources run only while powered
    // ********************************
    always_ff @(posedge core_clk) begin
        ref_one <= resetn && power_one && !ref_one;
        ref_two <= resetn && power_two && !ref_two;
    end
endmodule

// >>> rsm_top.sv
`timescale 1ns/1ps
// Contract
// - 10101 drives selected reference good, inverted
// - 10110 drives unselected good inverted; not differential
// - 10111/11000 drive inverted frequency-good of inputs
// - 11001 drives AND of both frequency-goods
// - 11010 drives lock AND selected AND oscillator
// - 11011 drives inverted oscillator frequency-good
// - 11100 low for second, high for first
// - 11101 lock low, 11110 holdover low, 11111 reserved
// - Top bit clear gives same signals active high
// - Bit 6 picks reference in manual register mode
// - Bit 5 picks register or pin selection
// - Auto switchover powers both inputs, ignores bits
// - Bit 3 clear reverts to first when good
// - Bits 2,1 power second and first inputs
// - Bit 0 picks single-ended or differential mode
module rsm_top
    import rsm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [9:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [4:0] monitor_sel,
    input  wire logic       reference_input_one,
    input  wire logic       reference_input_two,
    input  wire logic       ref_one_good,
    input  wire logic       ref_two_good,
    input  wire logic       ref_one_freq_good,
    input  wire logic       ref_two_freq_good,
    input  wire logic       osc_freq_good,
    input  wire logic       digital_lock_flag,
    input  wire logic       holdover_active,
    input  wire logic       ref_choice_pin,
    output logic            monitor_pin,
    output logic            selected_ref,
    output logic            ref_one_power_on,
    output logic            ref_two_power_on,
    output logic            diff_mode
);

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic [7:0] ctrl_r;
    wire        ctrl_hit = reg_addr == RSM_REF_CTRL_ADDR;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl_r <= RSM_REF_CTRL_RST;
        end else if (reg_wr && ctrl_hit) begin
            ctrl_r <= reg_wdata;
        end
    end

    assign reg_rdata = ctrl_hit ? ctrl_r : 8'h00;

    wire deglitch_off = ctrl_r[RSM_BIT_DEGLITCH_OFF];
    wire manual_sel   = ctrl_r[RSM_BIT_MANUAL_SEL];
    wire use_pin      = ctrl_r[RSM_BIT_USE_PIN];
    wire auto_switch  = ctrl_r[RSM_BIT_AUTO_SWITCH];
    wire keep_second_reference = ctrl_r[RSM_BIT_KEEP_SECOND];
    wire diff_en      = ctrl_r[RSM_BIT_DIFF_MODE];

    // ****************************************************************
    // Reference choice
    // ****************************************************************
    // Manual choice: register bit or external pin
    wire manual_choice = use_pin ? ref_choice_pin : manual_sel;

    rsm_auto_t auto_r;
    rsm_auto_t auto_nxt;

    always_comb begin
        auto_nxt = auto_r;
        unique case (auto_r)
            RSM_ON_FIRST: begin
                if (!ref_one_good && ref_two_good) begin
                    auto_nxt = RSM_ON_SECOND;
                end
            end
            RSM_ON_SECOND: begin
                if (ref_one_good && !keep_second_reference) begin
                    auto_nxt = RSM_ON_FIRST;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn || !auto_switch) begin
            auto_r <= RSM_ON_FIRST;
        end else begin
            auto_r <= auto_nxt;
        end
    end

    // Differential mode runs only on the first input path
    wire sel_req = diff_en ? 1'b0 : (auto_switch ? (auto_r == RSM_ON_SECOND) : manual_choice);
    wire sel_now;

    rsm_deglitch u_deglitch (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .bypass      (deglitch_off),
        .sel_req     (sel_req),
        .sel_applied (sel_now)
    );

    // ****************************************************************
    // Monitor multiplexer
    // ****************************************************************
    wire sel_good   = sel_now ? ref_two_good : ref_one_good;
    wire unsel_good = diff_en ? 1'b0 : (sel_now ? ref_one_good : ref_two_good);
    wire sel_clk    = sel_now ? reference_input_two : reference_input_one;
    wire unsel_clk  = diff_en ? 1'b0 : (sel_now ? reference_input_one : reference_input_two);

    // Status in active-high form for each code
    function automatic logic mon_status(input logic [3:0] code);
        logic s;
        s = 1'b0;
        unique case (code)
            RSM_MON_RAIL:       s = 1'b0;
            RSM_MON_REF_ONE:    s = reference_input_one;
            RSM_MON_REF_TWO:    s = diff_en ? 1'b0 : reference_input_two;
            RSM_MON_SEL_CLK:    s = sel_clk;
            RSM_MON_UNSEL_CLK:  s = unsel_clk;
            RSM_MON_SEL_GOOD:   s = sel_good;
            RSM_MON_UNSEL_GOOD: s = unsel_good;
            RSM_MON_ONE_FREQ:   s = ref_one_freq_good;
            RSM_MON_TWO_FREQ:   s = ref_two_freq_good;
            RSM_MON_BOTH_FREQ:  s = ref_one_freq_good & ref_two_freq_good;
            RSM_MON_LOCK_ALL:   s = digital_lock_flag & sel_good & osc_freq_good;
            RSM_MON_OSC_FREQ:   s = osc_freq_good;
            RSM_MON_WHICH_REF:  s = sel_now;
            RSM_MON_LOCK:       s = digital_lock_flag;
            RSM_MON_HOLDOVER:   s = holdover_active;
            RSM_MON_RESERVED:   s = 1'b0;
        endcase
        return s;
    endfunction

    // Codes whose level keeps its sense in the upper half
    function automatic logic mon_keeps_sense(input logic [3:0] code);
        return code == RSM_MON_REF_ONE || code == RSM_MON_REF_TWO || code == RSM_MON_SEL_CLK
            || code == RSM_MON_UNSEL_CLK || code == RSM_MON_BOTH_FREQ || code == RSM_MON_LOCK_ALL
            || code == RSM_MON_RESERVED;
    endfunction

    wire [3:0] mon_code   = monitor_sel[3:0];
    wire       mon_high   = monitor_sel[4];
    logic      mon_stat;
    wire       mon_rail   = mon_code == RSM_MON_RAIL;
    wire       mon_invert = mon_high && !mon_keeps_sense(mon_code);
    wire       mon_nxt    = mon_rail ? mon_high : (mon_invert ? ~mon_stat : mon_stat);

    // Procedural, so every status the function reads wakes it up
    always_comb begin
        mon_stat = mon_status(mon_code);
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            monitor_pin      <= 1'b0;
            selected_ref     <= 1'b0;
            ref_one_power_on <= 1'b0;
            ref_two_power_on <= 1'b0;
            diff_mode        <= 1'b0;
        end else begin
            monitor_pin      <= mon_nxt;
            selected_ref     <= sel_now;
            ref_one_power_on <= auto_switch | ctrl_r[RSM_BIT_REF_ONE_PWR];
            ref_two_power_on <= auto_switch | ctrl_r[RSM_BIT_REF_TWO_PWR];
            diff_mode        <= diff_en;
        end
    end

endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import rsm_pkg::*;
    logic       core_clk = 0, resetn = 0, reg_wr = 0, ref_choice_pin = 0;
    logic [9:0] reg_addr = RSM_REF_CTRL_ADDR;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, w;
    logic [4:0] monitor_sel = 5'h00;
    logic       ref_one_good = 0, ref_two_good = 0, ref_one_freq_good = 0, ref_two_freq_good = 0;
    logic       osc_freq_good = 0, digital_lock_flag = 0, holdover_active = 0, ref_one_r = 0, ref_two_r = 0;
    logic       reference_input_one, reference_input_two, monitor_pin, selected_ref;
    logic       ref_one_power_on, ref_two_power_on, diff_mode;
    int         err_total = 0, n_tests = 0, cyc = 0, n;
    always #4 core_clk = ~core_clk;
    // Reference levels as the design sampled them at the last edge
    always @(posedge core_clk) {ref_one_r, ref_two_r} <= {reference_input_one, reference_input_two};
    rsm_top DUT (.core_clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .monitor_sel,
        .reference_input_one, .reference_input_two, .ref_one_good, .ref_two_good, .ref_one_freq_good,
        .ref_two_freq_good, .osc_freq_good, .digital_lock_flag, .holdover_active, .ref_choice_pin,
        .monitor_pin, .selected_ref, .ref_one_power_on, .ref_two_power_on, .diff_mode);
    rsm_ref_src src (.core_clk, .resetn, .power_one(ref_one_power_on), .power_two(ref_two_power_on),
        .ref_one(reference_input_one), .ref_two(reference_input_two));
    // ********************************
    // Helpers
    // ********************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge core_clk);
        reg_wr = 0;
        reg_addr = RSM_REF_CTRL_ADDR;
        #1;
    endtask
    task automatic swait(input logic e, input int exp);
        n = 0;
        while (selected_ref !== e && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        chk(8'(selected_ref), 8'(e));
        if (exp > 0) chk(8'(n), 8'(exp));
    endtask
    function automatic logic em(logic [4:0] c, logic es, logic ed);
        logic v;
        case (c[3:0])
            RSM_MON_REF_ONE:    return ref_one_r;
            RSM_MON_REF_TWO:    return ed ? 1'b0 : ref_two_r;
            RSM_MON_SEL_CLK:    return es ? ref_two_r : ref_one_r;
            RSM_MON_UNSEL_CLK:  return ed ? 1'b0 : (es ? ref_one_r : ref_two_r);
            RSM_MON_SEL_GOOD:   v = es ? ref_two_good : ref_one_good;
            RSM_MON_UNSEL_GOOD: v = ed ? 1'b0 : (es ? ref_one_good : ref_two_good);
            RSM_MON_ONE_FREQ:   v = ref_one_freq_good;
            RSM_MON_TWO_FREQ:   v = ref_two_freq_good;
            RSM_MON_BOTH_FREQ:  return ref_one_freq_good & ref_two_freq_good;
            RSM_MON_LOCK_ALL:   return digital_lock_flag & osc_freq_good & (es ? ref_two_good : ref_one_good);
            RSM_MON_OSC_FREQ:   v = osc_freq_good;
            RSM_MON_WHICH_REF:  v = es;
            RSM_MON_LOCK:       v = digital_lock_flag;
            RSM_MON_HOLDOVER:   v = holdover_active;
            default:            return c[4];
        endcase
        return c[4] ? !v : v;
    endfunction
    task summarize;
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end
    // ********************************
    // Tests
    // ********************************
    initial begin
        void'($urandom(32'h686C));
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1;
        #1;
        chk(reg_rdata, RSM_REF_CTRL_RST);
        chk(8'({selected_ref, ref_one_power_on, ref_two_power_on, diff_mode}), 8'h00);
        $display("reset test done");
        repeat (20) begin
            w = 8'($urandom);
            if (w[0]) w[4:1] = 4'h0;
            wr(RSM_REF_CTRL_ADDR, w);
            chk(reg_rdata, w);
            wr(10'h01D, ~w);
            chk(reg_rdata, w);
            chk(8'({ref_one_power_on, ref_two_power_on, diff_mode}), 8'({w[1] | w[4], w[2] | w[4], w[0]}));
            reg_addr = 10'h3FF;
            #1 chk(reg_rdata, 8'h00);
        end
        $display("register test done");
        wr(RSM_REF_CTRL_ADDR, 8'h00);
        swait(0, 0);
        wr(RSM_REF_CTRL_ADDR, 8'h40);
        swait(1, RSM_DEGLITCH_CYCLES + 1);
        wr(RSM_REF_CTRL_ADDR, 8'h80);
        swait(0, 2);
        wr(RSM_REF_CTRL_ADDR, 8'hA0);
        ref_choice_pin = 1;
        swait(1, 0);
        ref_choice_pin = 0;
        $display("selection test done");
        ref_two_good = 1;
        wr(RSM_REF_CTRL_ADDR, 8'h90);
        swait(1, 0);
        chk(8'({ref_one_power_on, ref_two_power_on}), 8'h03);
        ref_one_good = 1;
        swait(0, 0);
        wr(RSM_REF_CTRL_ADDR, 8'h98);
        ref_one_good = 0;
        swait(1, 0);
        ref_one_good = 1;
        repeat (12) @(negedge core_clk);
        chk(8'(selected_ref), 8'h01);
        $display("switchover test done");
        foreach (w[i]) if (i < 2) begin
            wr(RSM_REF_CTRL_ADDR, i ? 8'h81 : 8'hC6);
            repeat (3) @(negedge core_clk);
            chk(8'(selected_ref), 8'(i == 0));
            for (int c = 0; c < 32; c++) if (c[3:0] != 4'hF) begin
                @(negedge core_clk);
                {ref_one_good, ref_two_good, ref_one_freq_good, ref_two_freq_good} = 4'($urandom);
                {osc_freq_good, digital_lock_flag, holdover_active} = 3'($urandom);
                monitor_sel = 5'(c);
                @(negedge core_clk);
                chk(8'(monitor_pin), 8'(em(5'(c), i == 0, i == 1)));
            end
        end
        $display("monitor test done");
        summarize();
    end
endmodule
